// ==== awss_bclk_div.v ====
// External bus clock enable divider.
`timescale 1ns/1ps
module awss_bclk_div (
	// Clock and reset
	input wire clk,
	input wire srst,
	// Divider setting: one tick every div+1 clocks
	input wire [7:0] div,
	// Bus clock enable pulse
	output reg tick
);
	reg [7:0] cnt;

	always @(posedge clk) begin
		if (srst) begin
			cnt <= 8'h00;
			tick <= 1'b0;
		end else if (cnt >= div) begin
			cnt <= 8'h00;
			tick <= 1'b1;
		end else begin
			cnt <= cnt + 8'h01;
			tick <= 1'b0;
		end
	end
endmodule // awss_bclk_div

// ==== awss_defs.vh ====
// Constants for the area wait state select register bank.
`ifndef AWSS_DEFS_VH
`define AWSS_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define AWSS_OFF_WAIT_HI 8'h00
`define AWSS_OFF_WAIT_LO 8'h04
`define AWSS_OFF_AST 8'h08
`define AWSS_OFF_BCLK_DIV 8'h0C
`define AWSS_OFF_STATUS 8'h10

// ----------------------------------------
// Field layout and reset values
// ----------------------------------------
`define AWSS_WAIT_MASK 16'h7777
`define AWSS_WAIT_RESET 16'h7777
`define AWSS_AST_LSB 8
`define AWSS_AST_RESET 8'hFF
`define AWSS_DIV_RESET 8'h01
`define AWSS_ST_BUSY 0
`define AWSS_ST_AREA_LSB 4
`define AWSS_ST_REMAIN_LSB 8
`define AWSS_ST_COUNT_LSB 16

// ----------------------------------------
// Widths
// ----------------------------------------
`define AWSS_AREAS 8
`define AWSS_WCNT_W 3

`endif

// ==== awss_mem_model.sv ====
// Far-side memory model counting bus periods of each stretched access.
`timescale 1ns/1ps
module awss_mem_model (
	input wire clk,
	input wire srst,
	input wire acc_wait,
	input wire acc_done,
	input wire bclk_en,
	output reg [3:0] waits
);
	reg [3:0] cur;
	always @(posedge clk) begin
		if (srst) begin
			cur <= 4'h0;
			waits <= 4'h0;
		end else if (acc_done) begin
			waits <= cur;
			cur <= 4'h0;
		end else if (acc_wait && bclk_en) begin
			cur <= cur + 4'h1;
		end
	end
endmodule // awss_mem_model

// ==== awss_properties.sv ====
// Checker for the area wait state select bank.
`timescale 1ns/1ps
module awss_chk (
	input wire clk,
	input wire srst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire [31:0] prdata,
	input wire pslverr,
	input wire acc_start,
	input wire [2:0] acc_area,
	input wire acc_ready,
	input wire acc_wait,
	input wire acc_done,
	input wire bclk_en
);
	reg [15:0] hi;
	reg [15:0] lo;
	reg [7:0] ast;
	reg [2:0] rem;
	wire [15:0] wr = acc_area[2] ? hi : lo;
	wire [2:0] n = ast[acc_area] ? wr[acc_area[1:0]*4 +: 3] : 3'h0;
	wire tk = psel && penable && pready && pwrite;
	wire rd = pready && !pwrite && (paddr == 8'h00 || paddr == 8'h04);
	// Shadow copies let the checker predict counts without seeing the bodies.
	always @(posedge clk) begin
		if (srst) begin
			hi <= 16'h7777;
			lo <= 16'h7777;
			ast <= 8'hFF;
			rem <= 3'h0;
		end else begin
			if (tk && paddr == 8'h00) hi <= pwdata[15:0] & 16'h7777;
			if (tk && paddr == 8'h04) lo <= pwdata[15:0] & 16'h7777;
			if (tk && paddr == 8'h08) ast <= pwdata[15:8];
			if (acc_start && acc_ready) rem <= n;
			else if (acc_wait && bclk_en) rem <= rem - 3'h1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	sequence s_go; acc_start && acc_ready; endsequence
	sequence s_end; acc_done && !acc_wait; endsequence
	property p_rdy; psel && penable && !pready |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("pready late");
	property p_rsv; rd |-> (prdata & 32'hFFFF8888) == 32'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bit set");
	property p_rd; rd |-> prdata[15:0] == (paddr[2] ? lo : hi); endproperty
	a_rd: assert property (p_rd) else $error("wait read wrong");
	property p_zero; s_go ##0 (n == 3'h0) |=> s_end ##0 acc_ready; endproperty
	a_zero: assert property (p_zero) else $error("zero wait wrong");
	property p_wait; s_go ##0 (n != 3'h0) |=> acc_wait && !acc_ready; endproperty
	a_wait: assert property (p_wait) else $error("no wait");
	property p_cnt; acc_done |-> rem == 3'h0; endproperty
	a_cnt: assert property (p_cnt) else $error("early done");
	property p_hold; acc_wait |-> rem != 3'h0; endproperty
	a_hold: assert property (p_hold) else $error("wait too long");
	property p_fall; acc_wait && bclk_en && rem == 3'h1 |=> s_end; endproperty
	a_fall: assert property (p_fall) else $error("wait end wrong");
endmodule // awss_chk
bind awss_top awss_chk chk_u (
	.clk(clk),
	.srst(srst),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.pready(pready),
	.prdata(prdata),
	.pslverr(pslverr),
	.acc_start(acc_start),
	.acc_area(acc_area),
	.acc_ready(acc_ready),
	.acc_wait(acc_wait),
	.acc_done(acc_done),
	.bclk_en(bclk_en)
);

// ==== awss_top.v ====
// Area wait state select registers with APB access and wait insertion.
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
`include "awss_defs.vh"
module awss_top (
	// Clock and reset
	input wire clk,
	input wire srst,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg pready,
	output reg [31:0] prdata,
	output reg pslverr,
	// Access request from the bus controller
	input wire acc_start,
	input wire [2:0] acc_area,
	// Wait insertion status
	output reg acc_ready,
	output wire acc_wait,
	output wire acc_done,
	output wire bclk_en
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [15:0] wait_count_areas_7_to_4;
	reg [15:0] wait_count_areas_3_to_0;
	reg [7:0] access_state_control_reg;
	reg [7:0] bclk_div;
	reg [15:0] access_count;
	reg [2:0] last_area;

	wire timer_busy;
	wire [2:0] timer_remain;
	wire timer_done;
	wire tick;

	// ----------------------------------------
	// Per-area count selection
	// ----------------------------------------
	// Area n sits at bits 4*(n%4)+2 .. 4*(n%4) of its register.
	wire [31:0] wait_all;
	wire [23:0] eff_count;
	assign wait_all = {wait_count_areas_7_to_4, wait_count_areas_3_to_0};

	genvar a;
	generate
		for (a = 0; a < `AWSS_AREAS; a = a + 1) begin : g_area
			// A two-state area never stretches, whatever its count holds.
			assign eff_count[a*3 +: 3] = access_state_control_reg[a] ?
				wait_all[a*4 +: 3] : 3'h0;
		end
	endgenerate

	reg [2:0] sel_count;
	always @* begin
		sel_count = 3'h0;
		case (acc_area)
		3'd0: sel_count = eff_count[2:0];
		3'd1: sel_count = eff_count[5:3];
		3'd2: sel_count = eff_count[8:6];
		3'd3: sel_count = eff_count[11:9];
		3'd4: sel_count = eff_count[14:12];
		3'd5: sel_count = eff_count[17:15];
		3'd6: sel_count = eff_count[20:18];
		3'd7: sel_count = eff_count[23:21];
		default: sel_count = 3'h0;
		endcase
	end

	// ----------------------------------------
	// Access start
	// ----------------------------------------
	// A start while a previous access still waits is dropped; the caller
	// must watch acc_ready, since queueing would hide the stall length.
	wire start_ok;
	assign start_ok = acc_start & acc_ready;

	always @(posedge clk) begin
		if (srst) begin
			acc_ready <= 1'b1;
			access_count <= 16'h0000;
			last_area <= 3'h0;
		end else begin
			if (start_ok) begin
				access_count <= access_count + 16'h0001;
				last_area <= acc_area;
			end
			// Ready falls for a stretched access and returns the cycle after done.
			if (start_ok && sel_count != 3'h0) begin
				acc_ready <= 1'b0;
			end else if (timer_done) begin
				acc_ready <= 1'b1;
			end
		end
	end

	awss_bclk_div u_div (
		.clk(clk),
		.srst(srst),
		.div(bclk_div),
		.tick(tick)
	);

	awss_wait_timer u_timer (
		.clk(clk),
		.srst(srst),
		.start(start_ok),
		.count(sel_count),
		.tick(tick),
		.busy(timer_busy),
		.remain(timer_remain),
		.done(timer_done)
	);

	assign acc_wait = timer_busy;
	assign acc_done = timer_done;
	assign bclk_en = tick;

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// One wait state: the answer is prepared in the first access cycle so
	// that every bus output comes from a flip-flop.
	wire acc_phase;
	wire commit;
	wire mapped;
	assign acc_phase = psel & penable;
	assign commit = acc_phase & pready;
	assign mapped = (paddr == `AWSS_OFF_WAIT_HI) || (paddr == `AWSS_OFF_WAIT_LO) ||
		(paddr == `AWSS_OFF_AST) || (paddr == `AWSS_OFF_BCLK_DIV) ||
		(paddr == `AWSS_OFF_STATUS);

	reg [31:0] rd_value;
	always @* begin
		rd_value = 32'h0000_0000;
		case (paddr)
		`AWSS_OFF_WAIT_HI: rd_value = {16'h0000, wait_count_areas_7_to_4 & `AWSS_WAIT_MASK};
		`AWSS_OFF_WAIT_LO: rd_value = {16'h0000, wait_count_areas_3_to_0 & `AWSS_WAIT_MASK};
		`AWSS_OFF_AST: rd_value = {16'h0000, access_state_control_reg, 8'h00};
		`AWSS_OFF_BCLK_DIV: rd_value = {24'h000000, bclk_div};
		`AWSS_OFF_STATUS: begin
			rd_value[`AWSS_ST_BUSY] = timer_busy;
			rd_value[`AWSS_ST_AREA_LSB +: 3] = last_area;
			rd_value[`AWSS_ST_REMAIN_LSB +: 3] = timer_remain;
			rd_value[`AWSS_ST_COUNT_LSB +: 16] = access_count;
		end
		default: rd_value = 32'h0000_0000;
		endcase
	end

	always @(posedge clk) begin
		if (srst) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (acc_phase && !pready) begin
			pready <= 1'b1;
			prdata <= pwrite ? 32'h0000_0000 : rd_value;
			pslverr <= ~mapped;
		end else begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	// A count changed during an access takes effect on the next access only.
	always @(posedge clk) begin
		if (srst) begin
			wait_count_areas_7_to_4 <= `AWSS_WAIT_RESET;
			wait_count_areas_3_to_0 <= `AWSS_WAIT_RESET;
			access_state_control_reg <= `AWSS_AST_RESET;
			bclk_div <= `AWSS_DIV_RESET;
		end else if (commit && pwrite) begin
			case (paddr)
			`AWSS_OFF_WAIT_HI: wait_count_areas_7_to_4 <= pwdata[15:0] & `AWSS_WAIT_MASK;
			`AWSS_OFF_WAIT_LO: wait_count_areas_3_to_0 <= pwdata[15:0] & `AWSS_WAIT_MASK;
			`AWSS_OFF_AST: access_state_control_reg <= pwdata[`AWSS_AST_LSB +: 8];
			`AWSS_OFF_BCLK_DIV: bclk_div <= pwdata[7:0];
			default: ;
			endcase
		end
	end
endmodule // awss_top

// ==== awss_wait_timer.v ====
// Program wait cycle timer counted in bus clock periods.
`timescale 1ns/1ps
`include "awss_defs.vh"
module awss_wait_timer (
	// Clock and reset
	input wire clk,
	input wire srst,
	// Access start with its already qualified wait count
	input wire start,
	input wire [`AWSS_WCNT_W-1:0] count,
	input wire tick,
	// Timer state
	output reg busy,
	output reg [`AWSS_WCNT_W-1:0] remain,
	output reg done
);
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_WAIT = 2'b10;

	reg [1:0] state;

	always @(posedge clk) begin
		if (srst) begin
			state <= ST_IDLE;
			busy <= 1'b0;
			remain <= 3'h0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state)
			ST_IDLE: begin
				if (start) begin
					// A nonzero count is captured into remain here and counted down once per tick.
					if (count == 3'h0) begin
						done <= 1'b1;
					end else begin
						remain <= count;
						busy <= 1'b1;
						state <= ST_WAIT;
					end
				end
			end
			ST_WAIT: begin
				if (tick) begin
					remain <= remain - 3'h1;
					if (remain == 3'h1) begin
						busy <= 1'b0;
						done <= 1'b1;
						state <= ST_IDLE;
					end
				end
			end
			default: begin
				state <= ST_IDLE;
				busy <= 1'b0;
				remain <= 3'h0;
			end
			endcase
		end
	end
endmodule // awss_wait_timer

// ==== tb.sv ====
// Self-checking bench for the area wait state select bank.
`timescale 1ns/1ps
`include "awss_defs.vh"
module tb;
	reg clk = 0;
	reg srst = 1;
	reg psel = 0;
	reg penable = 0;
	reg pwrite = 0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0;
	reg acc_start = 0;
	reg [2:0] acc_area = 3'h0;
	wire pready, pslverr, acc_ready, acc_wait, acc_done, bclk_en;
	wire [31:0] prdata;
	wire [3:0] waits;
	integer mismatches = 0, cmp_count = 0, cyc = 0, i;
	reg [31:0] rd;
	reg err;
	awss_top dut_u (
		.clk(clk),
		.srst(srst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pready(pready),
		.prdata(prdata),
		.pslverr(pslverr),
		.acc_start(acc_start),
		.acc_area(acc_area),
		.acc_ready(acc_ready),
		.acc_wait(acc_wait),
		.acc_done(acc_done),
		.bclk_en(bclk_en)
	);
	awss_mem_model mem_u (
		.clk(clk),
		.srst(srst),
		.acc_wait(acc_wait),
		.acc_done(acc_done),
		.bclk_en(bclk_en),
		.waits(waits)
	);
	initial forever #5 clk = ~clk;
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			mismatches = mismatches + 1;
			stop_test;
		end
	end
	task stop_test;
		if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input string nm, input [31:0] s, input [31:0] e);
		cmp_count = cmp_count + 1;
		if (s !== e) begin
			mismatches = mismatches + 1;
			$display("Error %s exp %h got %h", nm, e, s);
		end
	endtask
	// The request stands until the edge at which pready is seen high; only the
	// bench timeout ends a wait.
	task apb(input w, input [7:0] a, input [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task acc(input [2:0] a, input [2:0] e);
		@(posedge clk);
		acc_start <= 1;
		acc_area <= a;
		@(posedge clk);
		acc_start <= 0;
		@(posedge clk);
		while (acc_done !== 1'b1) @(posedge clk);
		@(posedge clk);
		chk("waits", {28'h0, waits}, {29'h0, e});
		chk("ready", {31'h0, acc_ready}, 32'h1);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		srst <= 0;
		apb(0, `AWSS_OFF_WAIT_HI, 0);
		chk("hi", rd, 32'h7777);
		apb(0, `AWSS_OFF_WAIT_LO, 0);
		chk("lo", rd, 32'h7777);
		for (i = 0; i < 8; i = i + 1) acc(i[2:0], 3'h7);
		// Reserved bits are written as ones so a leak shows in the readback.
		apb(1, `AWSS_OFF_WAIT_HI, 32'hFFFFFEDC);
		apb(1, `AWSS_OFF_WAIT_LO, 32'hFFFFBA98);
		apb(0, `AWSS_OFF_WAIT_HI, 0);
		chk("hi", rd, 32'h7654);
		apb(0, `AWSS_OFF_WAIT_LO, 0);
		chk("lo", rd, 32'h3210);
		for (i = 0; i < 8; i = i + 1) acc(i[2:0], i[2:0]);
		apb(1, `AWSS_OFF_AST, 32'h5500);
		for (i = 0; i < 8; i = i + 1) acc(i[2:0], i[0] ? 3'h0 : i[2:0]);
		apb(0, 8'h40, 0);
		chk("slverr", {31'h0, err}, 32'h1);
		chk("rdata", rd, 32'h0);
		apb(1, `AWSS_OFF_BCLK_DIV, 32'h3);
		apb(0, `AWSS_OFF_BCLK_DIV, 0);
		chk("div", rd, 32'h3);
		acc(3'h6, 3'h6);
		apb(0, `AWSS_OFF_STATUS, 0);
		chk("status", rd, 32'h0019_0060);
		// A second reset must bring back the full count in every field of the high register.
		srst <= 1;
		repeat (2) @(posedge clk);
		srst <= 0;
		apb(0, `AWSS_OFF_WAIT_HI, 0);
		chk("hi", rd, 32'h7777);
		acc(3'h7, 3'h7);
		stop_test;
	end
endmodule // tb
